// File: hdl/dam_pd_timer.sv
// holds off reads after a deep precharge power-down exit
// assumes pdExit is a one-cycle pulse from the power-down sequencer
module dam_pd_timer (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pdExit,
  input  wire logic deepMode,
  input  wire logic allow,
  output logic      readHold
);
  dam_pkg::dam_pd_state_t state_r, state_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic       hold_r, hold_nxt;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    unique case (state_r)
      dam_pkg::DAM_IDLE: begin
        if (pdExit && allow && deepMode) begin
          state_nxt = dam_pkg::DAM_WAIT;
          cnt_nxt   = 8'(dam_pkg::XPDLL_CYC - 1);
        end
      end
      dam_pkg::DAM_WAIT: begin
        if (cnt_r == 8'h00) begin
          state_nxt = dam_pkg::DAM_IDLE;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
    endcase
    hold_nxt = (state_nxt == dam_pkg::DAM_WAIT);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= dam_pkg::DAM_IDLE;
      cnt_r   <= 8'h00;
      hold_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      hold_r  <= hold_nxt;
    end
  end

  assign readHold = hold_r;
endmodule

// File: hdl/dam_pkg.sv
// constants for the ddr3 address map and mode setup block
// assumes a 250 MHz controller clock and a classic wishbone register slave
// Operation
// - code 0001b: bank 15,14,13; row A10 from 16, A11 from 17
// - code 0010b: bank 15,14,13; row A10 28, A11 16, A12 17
// - code 0101b: bank 15,14,13; row A11 29, A12 16, A13 17
// - code 0110b: bank 16,15,14; row A11 29, A12 17; column A11 13
// - code 0111b: bank 15,14,13; row A12 30, A13 16, A14 17
// - code 1000b: bank 16,15,14; row A12 30, A13 17; column A11 13
// - code 1001b: bank 16,15,14; row A13 31, A14 17; column A11 13
// - code 1010b: bank 15,14,13; row A13 31, A14 16, A15 17
// - code 1011b: bank 16,15,14; row A14 32, A15 17; column A11 13
// - ganged mode: address bit 3 picks channel, all map bit numbers shift up one
// - one 4-bit map code per logical dimm, four logical dimms
// - mode setup fields go to MR0-MR3 at init; register resets to 0x00000004
// - for DDR2-1066 only the write-recovery field is passed on
// - bit 26 enables the multipurpose register as read data source
// - location field ignored while enable clear; only code 00b is used; with enable set the code passes bits 25:24 through
// - bit 23 selects precharge power-down entry and exit style
// - deep mode: wait at least 24ns after power-down exit before first read
package dam_pkg;
  localparam logic [7:0]  MAP_OFS       = 8'h80;
  localparam logic [7:0]  MODE_OFS      = 8'h84;
  localparam logic [7:0]  CTRL_OFS      = 8'h88;
  localparam logic [7:0]  STAT_OFS      = 8'h8C;
  localparam logic [31:0] MAP_RESET     = 32'h0000_0000;
  localparam logic [31:0] MODE_RESET    = 32'h0000_0004;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  localparam logic [31:0] MAP_WMASK     = 32'h0000_FFFF;
  localparam logic [31:0] MODE_WMASK    = 32'h07FF_FFFF;
  localparam logic [31:0] CTRL_WMASK    = 32'h0000_0007;
  localparam logic [31:0] TWR_MASK      = 32'h0000_0070;
  localparam int          MAP_CODE_W    = 4;
  localparam int          MPR_EN_BIT    = 26;
  localparam int          MPR_LOC_LSB   = 24;
  localparam int          PD_SEL_BIT    = 23;
  localparam int          GANG_BIT      = 0;
  localparam int          DDR2_BIT      = 1;
  localparam int          PD_ALLOW_BIT  = 2;
  localparam int          ST_HOLD_BIT   = 0;
  localparam int          ST_BADMAP_BIT = 1;
  localparam int          CLK_PERIOD_NS = 4;
  localparam int          XPDLL_NS      = 24;
  localparam int          XPDLL_CYC     = (XPDLL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0]  MPR_LOC_PATTERN = 2'h0;
  typedef enum logic {DAM_IDLE = 1'b0, DAM_WAIT = 1'b1} dam_pd_state_t;
endpackage

// File: hdl/dam_top.sv
// register file, ganged-mode address steering and mode outputs of the map block
// assumes a classic wishbone master and a dram init engine reading mrsFields
module dam_top #(
  parameter int ADDR_W = 40
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              wbCyc,
  input  wire logic              wbStb,
  input  wire logic              wbWe,
  input  wire logic [7:0]        wbAdr,
  input  wire logic [3:0]        wbSel,
  input  wire logic [31:0]       wbDatW,
  output logic [31:0]            wbDatR,
  output logic                   wbAck,
  input  wire logic              reqValid,
  input  wire logic [ADDR_W-1:0] reqAddr,
  input  wire logic [1:0]        reqDimm,
  input  wire logic              reqAutoPre,
  output logic                   xlatValid,
  output logic [2:0]             xlatBank,
  output logic [15:0]            xlatRow,
  output logic [11:0]            xlatCol,
  output logic                   xlatChannel,
  output logic                   xlatBadMap,
  output logic [31:0]            mrsFields,
  output logic                   mprEnable,
  output logic [1:0]             mprLocation,
  output logic                   pchgPdSelect,
  output logic                   powerdownAllow,
  input  wire logic              pdExit,
  output logic                   readHold
);
  logic [31:0] map_r, map_nxt, mode_r, mode_nxt, ctrl_r, ctrl_nxt;
  logic [31:0] rdat_r, rdat_nxt, mrs_r, mrs_nxt;
  logic        ack_r, ack_nxt, bad_r, bad_nxt;
  logic        multipurpose_readout_enable_r, multipurpose_readout_enable_nxt, pdSel_r, pdSel_nxt, allow_r, allow_nxt;
  logic [1:0]  multipurpose_location_r, multipurpose_location_nxt;
  logic [31:0] byteMask, statusWord;
  logic        access, wrMap, wrMode, wrCtrl, wrStat;
  logic        ganged, badPulse, holdNow;
  logic [3:0]  code;
  logic [ADDR_W-1:0] addrEff;

  // bus decode: one-cycle registered ack, unmapped reads return zero
  always_comb begin
    for (int b = 0; b < 4; b++) begin
      byteMask[8*b +: 8] = {8{wbSel[b]}};
    end
    access     = wbCyc && wbStb && !ack_r;
    wrMap      = access && wbWe && (wbAdr == dam_pkg::MAP_OFS);
    wrMode     = access && wbWe && (wbAdr == dam_pkg::MODE_OFS);
    wrCtrl     = access && wbWe && (wbAdr == dam_pkg::CTRL_OFS);
    wrStat     = access && wbWe && (wbAdr == dam_pkg::STAT_OFS);
    statusWord = '0;
    statusWord[dam_pkg::ST_HOLD_BIT]   = holdNow;
    statusWord[dam_pkg::ST_BADMAP_BIT] = bad_r;
    ack_nxt  = access;
    rdat_nxt = rdat_r;
    if (access) begin
      unique case (wbAdr)
        dam_pkg::MAP_OFS:  rdat_nxt = map_r;
        dam_pkg::MODE_OFS: rdat_nxt = mode_r;
        dam_pkg::CTRL_OFS: rdat_nxt = ctrl_r;
        dam_pkg::STAT_OFS: rdat_nxt = statusWord;
        default:           rdat_nxt = '0;
      endcase
    end
  end

  // register updates; reserved bits are masked to zero
  always_comb begin
    map_nxt  = map_r;
    mode_nxt = mode_r;
    ctrl_nxt = ctrl_r;
    if (wrMap) begin
      map_nxt = (map_r & ~byteMask) | (wbDatW & byteMask & dam_pkg::MAP_WMASK);
    end
    if (wrMode) begin
      mode_nxt = (mode_r & ~byteMask) | (wbDatW & byteMask & dam_pkg::MODE_WMASK);
    end
    if (wrCtrl) begin
      ctrl_nxt = (ctrl_r & ~byteMask) | (wbDatW & byteMask & dam_pkg::CTRL_WMASK);
    end
    // sticky bad-map flag: a new event wins over a write-one clear
    bad_nxt = bad_r;
    if (wrStat && wbSel[0] && wbDatW[dam_pkg::ST_BADMAP_BIT]) begin
      bad_nxt = 1'b0;
    end
    if (badPulse) begin
      bad_nxt = 1'b1;
    end
  end

  // mode values handed to the init engine and power-down logic
  always_comb begin
    if (ctrl_r[dam_pkg::DDR2_BIT]) begin
      mrs_nxt = mode_r & dam_pkg::TWR_MASK;
    end else begin
      mrs_nxt = mode_r;
    end
    multipurpose_readout_enable_nxt = mode_r[dam_pkg::MPR_EN_BIT];
    if (mode_r[dam_pkg::MPR_EN_BIT]) begin
      multipurpose_location_nxt = mode_r[dam_pkg::MPR_LOC_LSB +: 2];
    end else begin
      multipurpose_location_nxt = dam_pkg::MPR_LOC_PATTERN;
    end
    pdSel_nxt = mode_r[dam_pkg::PD_SEL_BIT];
    allow_nxt = ctrl_r[dam_pkg::PD_ALLOW_BIT];
  end

  // ganged mode moves every map bit up by one and bit 3 names the channel
  always_comb begin
    ganged = ctrl_r[dam_pkg::GANG_BIT];
    code   = map_r[reqDimm*dam_pkg::MAP_CODE_W +: dam_pkg::MAP_CODE_W];
    if (ganged) begin
      addrEff = reqAddr >> 1;
    end else begin
      addrEff = reqAddr;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      map_r    <= dam_pkg::MAP_RESET;
      mode_r   <= dam_pkg::MODE_RESET;
      ctrl_r   <= dam_pkg::CTRL_RESET;
      rdat_r   <= '0;
      ack_r    <= 1'b0;
      bad_r    <= 1'b0;
      mrs_r    <= '0;
      multipurpose_readout_enable_r  <= 1'b0;
      multipurpose_location_r <= 2'h0;
      pdSel_r  <= 1'b0;
      allow_r  <= 1'b0;
    end else begin
      map_r    <= map_nxt;
      mode_r   <= mode_nxt;
      ctrl_r   <= ctrl_nxt;
      rdat_r   <= rdat_nxt;
      ack_r    <= ack_nxt;
      bad_r    <= bad_nxt;
      mrs_r    <= mrs_nxt;
      multipurpose_readout_enable_r  <= multipurpose_readout_enable_nxt;
      multipurpose_location_r <= multipurpose_location_nxt;
      pdSel_r  <= pdSel_nxt;
      allow_r  <= allow_nxt;
    end
  end

  dam_xlat #(
    .ADDR_W (ADDR_W)
  ) uXlat (
    .clk        (clk),
    .rst        (rst),
    .inValid    (reqValid),
    .inAddr     (addrEff),
    .inCode     (code),
    .inAutoPre  (reqAutoPre),
    .inChannel  (ganged && reqAddr[3]),
    .outValid   (xlatValid),
    .outBank    (xlatBank),
    .outRow     (xlatRow),
    .outCol     (xlatCol),
    .outChannel (xlatChannel),
    .outBadMap  (badPulse)
  );

  dam_pd_timer uPdTimer (
    .clk      (clk),
    .rst      (rst),
    .pdExit   (pdExit),
    .deepMode (!pdSel_r),
    .allow    (allow_r),
    .readHold (holdNow)
  );

  assign xlatBadMap     = badPulse;
  assign readHold       = holdNow;
  assign wbDatR         = rdat_r;
  assign wbAck          = ack_r;
  assign mrsFields      = mrs_r;
  assign mprEnable      = multipurpose_readout_enable_r;
  assign mprLocation    = multipurpose_location_r;
  assign pchgPdSelect   = pdSel_r;
  assign powerdownAllow = allow_r;
endmodule

// File: hdl/dam_xlat.sv
// translates one system address into ddr3 bank, row and column
// assumes address already shifted for ganged mode; outputs are registered
module dam_xlat #(
  parameter int ADDR_W = 40
) (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              inValid,
  input  wire logic [ADDR_W-1:0] inAddr,
  input  wire logic [3:0]        inCode,
  input  wire logic              inAutoPre,
  input  wire logic              inChannel,
  output logic                   outValid,
  output logic [2:0]             outBank,
  output logic [15:0]            outRow,
  output logic [11:0]            outCol,
  output logic                   outChannel,
  output logic                   outBadMap
);
  logic        valid_r, valid_nxt, chan_r, chan_nxt, bad_r, bad_nxt;
  logic [2:0]  bank_r, bank_nxt;
  logic [15:0] row_r, row_nxt;
  logic [11:0] col_r, col_nxt;
  int          nHigh;
  logic        isX4, codeOk;

  always_comb begin
    nHigh  = 0;
    isX4   = 1'b0;
    codeOk = 1'b1;
    unique case (inCode)
      4'h1: nHigh = 0;
      4'h2: nHigh = 1;
      4'h5: nHigh = 2;
      4'h6: begin nHigh = 2; isX4 = 1'b1; end
      4'h7: nHigh = 3;
      4'h8: begin nHigh = 3; isX4 = 1'b1; end
      4'h9: begin nHigh = 4; isX4 = 1'b1; end
      4'hA: nHigh = 4;
      4'hB: begin nHigh = 5; isX4 = 1'b1; end
      default: codeOk = 1'b0;
    endcase
  end

  always_comb begin
    row_nxt = '0;
    col_nxt = '0;
    for (int i = 0; i < 10; i++) begin
      row_nxt[i] = inAddr[18+i];
      col_nxt[i] = inAddr[3+i];
    end
    col_nxt[10] = inAutoPre;
    for (int i = 0; i < 5; i++) begin
      if (i < nHigh) begin
        row_nxt[10+i] = inAddr[28+i];
      end
    end
    if (isX4) begin
      row_nxt[10+nHigh] = inAddr[17];
      col_nxt[11]       = inAddr[13];
      bank_nxt          = {inAddr[16], inAddr[15], inAddr[14]};
    end else begin
      row_nxt[10+nHigh] = inAddr[16];
      row_nxt[11+nHigh] = inAddr[17];
      bank_nxt          = {inAddr[15], inAddr[14], inAddr[13]};
    end
    if (!codeOk) begin
      row_nxt  = '0;
      col_nxt  = '0;
      bank_nxt = '0;
    end
    valid_nxt = inValid;
    chan_nxt  = inChannel;
    bad_nxt   = inValid && !codeOk;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      valid_r <= 1'b0;
      chan_r  <= 1'b0;
      bad_r   <= 1'b0;
      bank_r  <= '0;
      row_r   <= '0;
      col_r   <= '0;
    end else begin
      valid_r <= valid_nxt;
      chan_r  <= chan_nxt;
      bad_r   <= bad_nxt;
      bank_r  <= bank_nxt;
      row_r   <= row_nxt;
      col_r   <= col_nxt;
    end
  end

  assign outValid   = valid_r;
  assign outBank    = bank_r;
  assign outRow     = row_r;
  assign outCol     = col_r;
  assign outChannel = chan_r;
  assign outBadMap  = bad_r;
endmodule

// File: test/dam_assertions.sv
// concurrent checks on the ports of the address map block
// assumes one clock domain with an asynchronous active-high reset
module dam_assertions (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        wbCyc,
  input wire logic        wbStb,
  input wire logic        wbAck,
  input wire logic        reqValid,
  input wire logic        reqAutoPre,
  input wire logic        xlatValid,
  input wire logic [2:0]  xlatBank,
  input wire logic [15:0] xlatRow,
  input wire logic [11:0] xlatCol,
  input wire logic        xlatBadMap,
  input wire logic        mprEnable,
  input wire logic [1:0]  mprLocation,
  input wire logic        pchgPdSelect,
  input wire logic        powerdownAllow,
  input wire logic        pdExit,
  input wire logic        readHold
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_req; wbCyc && wbStb && !wbAck; endsequence
  sequence s_deep_exit; pdExit && powerdownAllow && !pchgPdSelect && !readHold; endsequence
  sequence s_hold; readHold [*6] ##1 !readHold; endsequence
  a_ack_next: assert property (s_req |=> wbAck) else $error("ack late");
  a_ack_drops: assert property (wbAck |=> !wbAck) else $error("ack held");
  a_xlat_latency: assert property (reqValid |=> xlatValid) else $error("no xlat");
  a_xlat_cause: assert property (xlatValid |-> $past(reqValid)) else $error("stray xlat");
  a_col_autopre: assert property (reqValid |=> xlatBadMap ||
    xlatCol[10] == $past(reqAutoPre)) else $error("col A10 wrong");
  a_bad_zero: assert property (xlatBadMap |-> xlatValid && xlatBank == 3'h0 &&
    xlatRow == 16'h0 && xlatCol == 12'h0) else $error("reserved code translated");
  a_mpr_gate: assert property (!mprEnable |-> mprLocation == 2'h0)
    else $error("location not ignored");
  a_deep_hold: assert property (s_deep_exit |=> s_hold) else $error("hold length");
  a_dyn_nohold: assert property ((pchgPdSelect || !powerdownAllow) && !readHold
    |=> !readHold) else $error("hold in dynamic mode");
endmodule

// File: test/dam_dram_model.sv
// far-side model: dram exits precharge power-down and counts blocked cycles
// assumes go is a one-cycle request from the bench
module dam_dram_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic go,
  input wire logic readHold,
  output logic     pdExit,
  output int       holdCycles
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pdExit <= 1'b0;
      holdCycles <= 0;
    end else begin
      pdExit <= go;
      holdCycles <= go ? 0 : holdCycles + int'(readHold);
    end
  end
endmodule

// File: test/dam_top_test.sv
// self-checking bench for the address map and mode setup block
// assumes the checker and dram model files are compiled before it
module dam_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, wbCyc = 0, wbStb = 0, wbWe = 0, reqValid = 0, reqAutoPre = 0;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatW = 32'h0, wbDatR, mrsFields, rd;
  logic [39:0] reqAddr = 40'h0;
  logic [1:0] reqDimm = 2'h0, mprLocation;
  logic wbAck, xlatValid, xlatChannel, xlatBadMap, mprEnable, pchgPdSelect;
  logic powerdownAllow, pdExit, readHold, go = 0;
  logic [2:0] xlatBank;
  logic [15:0] xlatRow;
  logic [11:0] xlatCol;
  int num_errors = 0, total_checks = 0, holdCycles;
  always #2 clk = ~clk;
  dam_top #(.ADDR_W(40)) i_dam_top (.clk, .rst, .wbCyc, .wbStb, .wbWe, .wbAdr, .wbSel,
    .wbDatW, .wbDatR, .wbAck, .reqValid, .reqAddr, .reqDimm, .reqAutoPre, .xlatValid,
    .xlatBank, .xlatRow, .xlatCol, .xlatChannel, .xlatBadMap, .mrsFields, .mprEnable,
    .mprLocation, .pchgPdSelect, .powerdownAllow, .pdExit, .readHold);
  dam_dram_model i_dam_dram_model (.clk, .rst, .go, .readHold, .pdExit, .holdCycles);
  task automatic chk(input logic [63:0] s, input logic [63:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, s, e);
    end
  endtask
  task automatic report_and_stop;
    $display("errors=%0d checks=%0d", num_errors, total_checks);
    if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    {wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatW} <= {2'b11, we, adr, 4'hF, d};
    do @(posedge clk); while (wbAck !== 1'b1 && ++n < 50);
    if (n >= 50) num_errors++;
    rd = wbDatR;
    {wbCyc, wbStb} <= 2'b00;
  endtask
  function automatic logic [31:0] ex(logic [3:0] c, logic [39:0] ad, logic ap, logic g);
    logic [39:0] a;
    logic [15:0] r;
    logic x4;
    int n;
    a = g ? ad >> 1 : ad;
    x4 = c inside {4'h6, 4'h8, 4'h9, 4'hB};
    case (c)
      4'h1: n = 0;
      4'h2: n = 1;
      4'h5, 4'h6: n = 2;
      4'h7, 4'h8: n = 3;
      4'h9, 4'hA: n = 4;
      4'hB: n = 5;
      default: return 32'h8000_0000;
    endcase
    r = {6'h00, a[27:18]};
    for (int i = 0; i < n; i++) r[10+i] = a[28+i];
    if (x4) r[10+n] = a[17];
    else {r[11+n], r[10+n]} = a[17:16];
    return {1'b0, x4 ? a[16:14] : a[15:13], r, x4 & a[13], ap, a[12:3]};
  endfunction
  task automatic xl(input logic [3:0] c, input logic g, input logic [1:0] d);
    logic [39:0] a;
    logic ap;
    a = 40'({$urandom, $urandom});
    ap = 1'($urandom);
    @(posedge clk);
    {reqValid, reqAddr, reqDimm, reqAutoPre} <= {1'b1, a, d, ap};
    @(posedge clk);
    reqValid <= 1'b0;
    #1;
    chk({xlatValid, xlatBadMap, xlatBank, xlatRow, xlatCol}, {1'b1, ex(c, a, ap, g)});
    chk(xlatChannel, g & a[3]);
  endtask
  task automatic pd(input logic [31:0] ctrl, input logic [31:0] mode, input int e);
    wb(1'b1, dam_pkg::CTRL_OFS, ctrl);
    wb(1'b1, dam_pkg::MODE_OFS, mode);
    repeat (2) @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (12) @(posedge clk);
    #1 chk(holdCycles, e);
    chk(powerdownAllow, ctrl[dam_pkg::PD_ALLOW_BIT]);
  endtask
  initial begin
    #100000;
    num_errors++;
    report_and_stop;
  end
  initial begin
    logic [1:0] d;
    void'($urandom(32'hC0FB902B));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, dam_pkg::MAP_OFS, 32'h0);
    chk(rd, 32'h0);
    wb(1'b0, dam_pkg::MODE_OFS, 32'h0);
    chk({rd, mrsFields}, {2{32'h0000_0004}});
    wb(1'b1, dam_pkg::MODE_OFS, 32'h04FF_FFFF);
    wb(1'b0, dam_pkg::MODE_OFS, 32'h0);
    #1 chk({rd, mrsFields}, {2{32'h04FF_FFFF}});
    chk({mprEnable, mprLocation, pchgPdSelect}, 4'h9);
    wb(1'b1, dam_pkg::CTRL_OFS, 32'h2);
    repeat (2) @(posedge clk);
    #1 chk(mrsFields, 32'h04FF_FFFF & dam_pkg::TWR_MASK);
    wb(1'b1, dam_pkg::MODE_OFS, 32'h0300_0000);
    repeat (2) @(posedge clk);
    #1 chk({mprEnable, mprLocation}, 3'h0);
    wb(1'b0, 8'h90, 32'h0);
    chk(rd, 32'h0);
    for (int c = 0; c < 16; c++) begin
      for (int g = 0; g < 2; g++) begin
        d = 2'($urandom);
        wb(1'b1, dam_pkg::CTRL_OFS, 32'(g));
        wb(1'b1, dam_pkg::MAP_OFS, (32'h5555 & ~(32'hF << 4 * d)) | (32'(c) << 4 * d));
        repeat (2) xl(4'(c), 1'(g), d);
        repeat (2) xl(4'(c), 1'(g), d);
      end
    end
    wb(1'b0, dam_pkg::STAT_OFS, 32'h0);
    chk(rd[dam_pkg::ST_BADMAP_BIT], 1'b1);
    wb(1'b1, dam_pkg::STAT_OFS, 32'h2);
    wb(1'b0, dam_pkg::STAT_OFS, 32'h0);
    chk(rd[dam_pkg::ST_BADMAP_BIT], 1'b0);
    pd(32'h4, 32'h4, dam_pkg::XPDLL_CYC);
    pd(32'h4, 32'h0080_0004, 0);
    pd(32'h0, 32'h4, 0);
    // mid-run reset must bring the mode word back to its reset value
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, dam_pkg::MODE_OFS, 32'h0);
    chk({rd, mrsFields}, {dam_pkg::MODE_RESET, dam_pkg::MODE_RESET});
    report_and_stop;
  end
endmodule
bind dam_top dam_assertions i_dam_assertions (.clk, .rst, .wbCyc, .wbStb, .wbAck, .reqValid,
  .reqAutoPre, .xlatValid, .xlatBank, .xlatRow, .xlatCol, .xlatBadMap, .mprEnable,
  .mprLocation, .pchgPdSelect, .powerdownAllow, .pdExit, .readHold);
